// ===== core/level_sync.sv
// Two-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module level_sync #(
  parameter int unsigned W = 2
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule // level_sync

// ===== core/lp_tick_gen.sv
// Low-power tick divider: one-cycle enable per low-power clock period
`timescale 1ns/1ps
module lp_tick_gen #(
  parameter int unsigned DIV = sleep_timer_pkg::LP_DIV_CYCLES
) (
  input wire logic clock_in,
  input wire logic reset_in,
  output logic tick_out
);
  localparam int unsigned CW = sleep_timer_pkg::LP_DIV_W;
  logic [sleep_timer_pkg::LP_DIV_W-1:0] count_reg;
  logic [sleep_timer_pkg::LP_DIV_W-1:0] count_next;
  logic tick_reg;
  logic tick_next;

  always_comb
  begin
    tick_next = (count_reg == CW'(DIV - 1));
    count_next = tick_next ? '0 : count_reg + 1'b1;
  end

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      count_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;
endmodule // lp_tick_gen

// ===== core/radio_core_sleep_wake_timer.sv
// Radio core deep-sleep timer, wake interrupts and exchange memory bound check
// Notes on behaviour
// - Page layout field picks one of 24 exchange memory maps in 2 kB pages
// - Core access beyond the selected map sets the access error status
// - Writing one to the acknowledge bit clears the access error status
// - Core error interrupt is access error OR general error status
// - Exit always gives early wake interrupt first, then sleep exit interrupt
// - Early wake rises the assert lead in low-power cycles before expiry
// - Too small an assert lead still wakes, but actual sleep runs longer
// - Early wake falls the deassert lead in cycles before the period ends
// - On wake request early wake stays high until the deassert lead before the external high time ends
// - Setting the wake request raises early wake at once, forcing wake-up
// - In deep sleep the time base runs on the low-power clock
// - After expiry the timer waits in deep sleep until the core is powered
// - Expired, clocked and powered: leave deep sleep, pulse sleep exit
// - Deep sleep entry is refused while the wake request is held
// - The external wake disable bit makes the wake request ignored in deep sleep; a held request still refuses entry
// - Duration register holds the sleep time in low-power cycles
`timescale 1ns/1ps
module radio_core_sleep_wake_timer #(
  parameter int unsigned LP_DIV = sleep_timer_pkg::LP_DIV_CYCLES
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire sleep_timer_pkg::reg_req_t reg_req_in,
  output logic [31:0] reg_rdata_out,
  input wire logic xmem_access_valid_in,
  input wire logic [sleep_timer_pkg::XMEM_ADDR_W-1:0] xmem_addr_in,
  input wire logic core_error_int_status_in,
  input wire logic radio_domain_up_in,
  input wire logic core_clocks_enabled_in,
  output logic [4:0] xmem_page_layout_out,
  output logic core_error_irq_out,
  output logic early_wake_interrupt_out,
  output logic sleep_exit_interrupt_out,
  output logic radio_powerdown_allowed_out,
  output logic low_power_clock_select_out
);
  // ==========================================================
  // Decode
  function automatic logic [sleep_timer_pkg::XMEM_ADDR_W-1:0] xmem_limit(input logic [4:0] layout);
    // Unknown layouts map nothing, so every access flags
    if (layout < sleep_timer_pkg::XMEM_CASES)
      xmem_limit = {1'b0, 5'(layout + 5'h01), 11'h000};
    else
      xmem_limit = '0;
  endfunction

  logic lp_tick;
  logic [1:0] pwr_sync;
  logic powered;

  lp_tick_gen #(
    .DIV(LP_DIV)
  ) u_tick (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .tick_out(lp_tick)
  );

  level_sync #(
    .W(2)
  ) u_sync (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .async_in({radio_domain_up_in, core_clocks_enabled_in}),
    .sync_out(pwr_sync)
  );

  assign powered = &pwr_sync;

  // ==========================================================
  // State
  sleep_timer_pkg::sleep_state_t state_reg, state_next;
  logic [31:0] duration_reg, duration_next;
  logic [31:0] timing_reg, timing_next;
  logic [31:0] elapsed_reg, elapsed_next;
  logic [31:0] actual_reg, actual_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [4:0] map_reg, map_next;
  logic [9:0] ext_cnt_reg, ext_cnt_next;
  logic ds_on_reg, ds_on_next;
  logic ext_dis_reg, ext_dis_next;
  logic wake_req_reg, wake_req_next;
  logic err_reg, err_next;
  logic ext_active_reg, ext_active_next;
  logic early_reg, early_next;
  logic early_seen_reg, early_seen_next;
  logic exit_reg, exit_next;
  logic pdn_reg, pdn_next;

  logic [9:0] set_lead;
  logic [9:0] reset_lead;
  logic [9:0] ext_high;
  logic [31:0] remaining;
  logic wr_gp;
  logic wr_ds;
  logic fault;
  logic wake_fire;
  logic timed_early;

  always_comb
  begin
    set_lead = timing_reg[sleep_timer_pkg::TIM_SET_LSB +: sleep_timer_pkg::LEAD_W];
    reset_lead = timing_reg[sleep_timer_pkg::TIM_RESET_LSB +: sleep_timer_pkg::LEAD_W];
    ext_high = timing_reg[sleep_timer_pkg::TIM_EXT_LSB +: sleep_timer_pkg::LEAD_W];
    remaining = duration_reg - elapsed_reg;
    wr_gp = reg_req_in.write && (reg_req_in.addr == sleep_timer_pkg::OFS_GP_CTRL);
    wr_ds = reg_req_in.write && (reg_req_in.addr == sleep_timer_pkg::OFS_DS_CTRL);
    fault = xmem_access_valid_in && (xmem_addr_in >= xmem_limit(map_reg));
    wake_fire = (state_reg == sleep_timer_pkg::ST_SLEEP) && wake_req_reg && !ext_dis_reg
      && !ext_active_reg;

    state_next = state_reg;
    duration_next = duration_reg;
    timing_next = timing_reg;
    elapsed_next = elapsed_reg;
    actual_next = actual_reg;
    map_next = map_reg;
    ext_cnt_next = ext_cnt_reg;
    ds_on_next = ds_on_reg;
    ext_dis_next = ext_dis_reg;
    wake_req_next = wake_req_reg;
    ext_active_next = ext_active_reg;
    early_seen_next = early_seen_reg;
    exit_next = 1'b0;
    rdata_next = rdata_reg;

    // Set wins over a simultaneous acknowledge
    err_next = fault || (err_reg && !(wr_gp && reg_req_in.wdata[sleep_timer_pkg::GP_ACK_BIT]));

    if (reg_req_in.write)
    begin
      case (reg_req_in.addr)
        sleep_timer_pkg::OFS_GP_CTRL:
        begin
          map_next = reg_req_in.wdata[sleep_timer_pkg::GP_MAP_LSB +: sleep_timer_pkg::MAP_W];
          wake_req_next = reg_req_in.wdata[sleep_timer_pkg::GP_WAKE_BIT];
        end
        sleep_timer_pkg::OFS_DURATION: duration_next = reg_req_in.wdata;
        sleep_timer_pkg::OFS_TIMING: timing_next = reg_req_in.wdata;
        default:
        begin
        end
      endcase
    end

    if (wr_ds)
    begin
      ext_dis_next = reg_req_in.wdata[sleep_timer_pkg::EXT_DIS_BIT];
      if (!wake_req_reg && (state_reg == sleep_timer_pkg::ST_ACTIVE))
        ds_on_next = reg_req_in.wdata[sleep_timer_pkg::DS_ON_BIT];
    end

    case (state_reg)
      sleep_timer_pkg::ST_ACTIVE:
      begin
        if (ds_on_reg && !wake_req_reg)
        begin
          state_next = sleep_timer_pkg::ST_SLEEP;
          elapsed_next = '0;
          ext_active_next = 1'b0;
          early_seen_next = 1'b0;
        end
      end
      sleep_timer_pkg::ST_SLEEP:
      begin
        if (wake_fire)
        begin
          ext_active_next = 1'b1;
          ext_cnt_next = ext_high;
        end
        if (lp_tick)
        begin
          elapsed_next = 32'(elapsed_reg + 32'h1);
          if (ext_active_reg)
          begin
            ext_cnt_next = 10'(ext_cnt_reg - 10'h001);
            if (ext_cnt_reg <= 10'h001)
              state_next = sleep_timer_pkg::ST_WAIT_UP;
          end
          else if (remaining <= 32'h1)
            state_next = sleep_timer_pkg::ST_WAIT_UP;
        end
      end
      sleep_timer_pkg::ST_WAIT_UP:
      begin
        // Keeps counting so the recorded time shows any late power-up
        if (lp_tick)
          elapsed_next = 32'(elapsed_reg + 32'h1);
        if (powered && early_seen_reg && !early_reg)
        begin
          state_next = sleep_timer_pkg::ST_ACTIVE;
          exit_next = 1'b1;
          actual_next = elapsed_reg;
          ds_on_next = 1'b0;
          ext_active_next = 1'b0;
        end
      end
      default: state_next = sleep_timer_pkg::ST_ACTIVE;
    endcase

    timed_early = (state_reg == sleep_timer_pkg::ST_SLEEP) && !ext_active_reg
      && (remaining <= {22'h0, set_lead})
      && (remaining > {22'h0, reset_lead});
    // A missed lead still yields one early pulse before the exit
    early_next = timed_early || wake_fire
      || (ext_active_reg && (state_reg == sleep_timer_pkg::ST_SLEEP) && (ext_cnt_reg > reset_lead))
      || ((state_reg == sleep_timer_pkg::ST_WAIT_UP) && !early_seen_reg);
    if (early_next)
      early_seen_next = 1'b1;

    pdn_next = (state_next != sleep_timer_pkg::ST_ACTIVE);

    if (reg_req_in.read)
    begin
      case (reg_req_in.addr)
        sleep_timer_pkg::OFS_DS_CTRL: rdata_next = {30'h0, ext_dis_reg, ds_on_reg};
        sleep_timer_pkg::OFS_DURATION: rdata_next = duration_reg;
        sleep_timer_pkg::OFS_ACTUAL: rdata_next = actual_reg;
        sleep_timer_pkg::OFS_TIMING: rdata_next = timing_reg;
        sleep_timer_pkg::OFS_GP_CTRL: rdata_next = {20'h0, pdn_reg, err_reg, 1'b0, wake_req_reg, 3'h0, map_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_reg <= sleep_timer_pkg::ST_ACTIVE;
      duration_reg <= sleep_timer_pkg::DURATION_RESET;
      timing_reg <= sleep_timer_pkg::TIMING_RESET;
      elapsed_reg <= '0;
      actual_reg <= '0;
      rdata_reg <= '0;
      map_reg <= sleep_timer_pkg::MAP_RESET;
      ext_cnt_reg <= '0;
      ds_on_reg <= 1'b0;
      ext_dis_reg <= 1'b0;
      wake_req_reg <= 1'b0;
      err_reg <= 1'b0;
      ext_active_reg <= 1'b0;
      early_reg <= 1'b0;
      early_seen_reg <= 1'b0;
      exit_reg <= 1'b0;
      pdn_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      duration_reg <= duration_next;
      timing_reg <= timing_next;
      elapsed_reg <= elapsed_next;
      actual_reg <= actual_next;
      rdata_reg <= rdata_next;
      map_reg <= map_next;
      ext_cnt_reg <= ext_cnt_next;
      ds_on_reg <= ds_on_next;
      ext_dis_reg <= ext_dis_next;
      wake_req_reg <= wake_req_next;
      err_reg <= err_next;
      ext_active_reg <= ext_active_next;
      early_reg <= early_next;
      early_seen_reg <= early_seen_next;
      exit_reg <= exit_next;
      pdn_reg <= pdn_next;
    end
  end

  assign reg_rdata_out = rdata_reg;
  assign xmem_page_layout_out = map_reg;
  assign core_error_irq_out = err_reg || core_error_int_status_in;
  assign early_wake_interrupt_out = early_reg;
  assign sleep_exit_interrupt_out = exit_reg;
  assign radio_powerdown_allowed_out = pdn_reg;
  assign low_power_clock_select_out = pdn_reg;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  AST_ERR_SET: assert property (fault |=> err_reg && core_error_irq_out)
    else $error("access fault did not set error status");
  AST_ERR_ACK: assert property (err_reg && wr_gp && reg_req_in.wdata[sleep_timer_pkg::GP_ACK_BIT] && !fault
    |=> !err_reg)
    else $error("acknowledge did not clear error status");
  AST_IRQ_OR: assert property (core_error_int_status_in && !err_reg |-> core_error_irq_out)
    else $error("general error not seen on core error interrupt");
  AST_EXIT_AFTER_EARLY: assert property ($rose(exit_reg) |-> $past(early_seen_reg) && !early_reg)
    else $error("sleep exit without early wake first");
  AST_WAKE_NOW: assert property (wake_fire |=> early_reg && ext_active_reg)
    else $error("wake request did not raise early wake next cycle");
  AST_NO_ENTRY: assert property (wake_req_reg && state_reg == sleep_timer_pkg::ST_ACTIVE
    |=> state_reg == sleep_timer_pkg::ST_ACTIVE)
    else $error("deep sleep entered while wake request held");
  AST_EXT_OFF: assert property (state_reg == sleep_timer_pkg::ST_SLEEP && ext_dis_reg && !ext_active_reg
    |=> !ext_active_reg)
    else $error("disabled wake request was taken");
  AST_WAIT_POWER: assert property (state_reg == sleep_timer_pkg::ST_WAIT_UP && !powered
    |=> state_reg != sleep_timer_pkg::ST_ACTIVE && !exit_reg)
    else $error("left deep sleep before core was powered");
  AST_EXIT_RECORD: assert property (exit_reg |-> actual_reg == $past(elapsed_reg) && !pdn_reg)
    else $error("exit did not record sleep time");

  COV_TIMED: cover property (state_reg == sleep_timer_pkg::ST_SLEEP && !ext_active_reg ##1
    state_reg == sleep_timer_pkg::ST_WAIT_UP);
  COV_FORCED: cover property (wake_fire ##1 early_reg);
  COV_EXIT: cover property (exit_reg);
  COV_FAULT: cover property (fault && err_reg);
endmodule // radio_core_sleep_wake_timer

// ===== core/sleep_timer_pkg.sv
// Shared constants and types for the radio core sleep and wake timer
package sleep_timer_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLOCK_HZ = 250000000;
  localparam int unsigned LP_CLOCK_HZ = 32768;
  localparam int unsigned LP_DIV_CYCLES = CLOCK_HZ / LP_CLOCK_HZ;
  localparam int unsigned LP_DIV_W = 16;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_DS_CTRL = 8'h30;
  localparam logic [7:0] OFS_DURATION = 8'h34;
  localparam logic [7:0] OFS_ACTUAL = 8'h38;
  localparam logic [7:0] OFS_TIMING = 8'h3c;
  localparam logic [7:0] OFS_GP_CTRL = 8'h80;
  // ==========================================================
  // Field positions
  localparam int unsigned DS_ON_BIT = 0;
  localparam int unsigned EXT_DIS_BIT = 1;
  localparam int unsigned LEAD_W = 10;
  localparam int unsigned TIM_SET_LSB = 0;
  localparam int unsigned TIM_RESET_LSB = 10;
  localparam int unsigned TIM_EXT_LSB = 20;
  localparam int unsigned MAP_W = 5;
  localparam int unsigned GP_MAP_LSB = 0;
  localparam int unsigned GP_WAKE_BIT = 8;
  localparam int unsigned GP_ACK_BIT = 9;
  localparam int unsigned GP_ERR_BIT = 10;
  localparam int unsigned GP_PDN_BIT = 11;
  // ==========================================================
  // Reset values
  localparam logic [31:0] DURATION_RESET = 32'h0000_0000;
  localparam logic [31:0] TIMING_RESET = 32'h0020_0420;
  localparam logic [4:0] MAP_RESET = 5'h00;
  // ==========================================================
  // Exchange memory layout
  localparam int unsigned XMEM_ADDR_W = 17;
  localparam logic [4:0] XMEM_CASES = 5'h18;
  // ==========================================================
  // Types
  typedef struct packed {
    logic write;
    logic read;
    logic [7:0] addr;
    logic [31:0] wdata;
  } reg_req_t;
  typedef enum logic [1:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_WAIT_UP
  } sleep_state_t;
endpackage

// ===== testbench/tb.sv
// Self-checking testbench for the radio core sleep and wake timer
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // Signals and instance
  localparam int unsigned LPD = 4;
  logic clk;
  logic rst;
  sleep_timer_pkg::reg_req_t req;
  logic [31:0] rdata;
  logic xvalid;
  logic [16:0] xaddr;
  logic gen_err;
  logic radio_up;
  logic clk_en;
  logic [4:0] layout;
  logic err_irq;
  logic early;
  logic slp_exit;
  logic pdn;
  logic lp_sel;
  int bad_count;
  int samples_checked;
  logic [31:0] rv;
  int hi;
  bit first_ok;
  bit exited;

  radio_core_sleep_wake_timer #(.LP_DIV(LPD)) dut_u (
    .clock_in(clk),
    .reset_in(rst),
    .reg_req_in(req),
    .reg_rdata_out(rdata),
    .xmem_access_valid_in(xvalid),
    .xmem_addr_in(xaddr),
    .core_error_int_status_in(gen_err),
    .radio_domain_up_in(radio_up),
    .core_clocks_enabled_in(clk_en),
    .xmem_page_layout_out(layout),
    .core_error_irq_out(err_irq),
    .early_wake_interrupt_out(early),
    .sleep_exit_interrupt_out(slp_exit),
    .radio_powerdown_allowed_out(pdn),
    .low_power_clock_select_out(lp_sel)
  );

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    #1 req = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    #1 req = '0;
  endtask

  // Read data is registered, so it is taken one edge after the strobe
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    #1 req = '{write: 1'b0, read: 1'b1, addr: a, wdata: 32'h0000_0000};
    @(posedge clk);
    #1 req = '0;
    d = rdata;
  endtask

  task automatic xacc(input logic [16:0] a);
    @(posedge clk);
    #1 xvalid = 1'b1;
    xaddr = a;
    @(posedge clk);
    #1 xvalid = 1'b0;
  endtask

  // Watches one sleep phase; notes early wake high time and order of exit
  task automatic run_sleep(input int lim, output int h, output bit ok, output bit ex);
    bit seen;
    int n;
    seen = 0;
    h = 0;
    ok = 0;
    ex = 0;
    n = 0;
    while (n < lim && !ex)
    begin
      @(posedge clk);
      #1 n++;
      if (early === 1'b1)
      begin
        h++;
        seen = 1;
      end
      if (slp_exit === 1'b1)
      begin
        ex = 1;
        ok = seen && (early === 1'b0);
      end
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Watchdog
  initial
  begin
    #60000;
    bad_count++;
    wrap_up();
  end

  // ==========================================================
  // Tests
  initial
  begin
    bad_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    req = '0;
    xvalid = 1'b0;
    xaddr = 17'h0_0000;
    gen_err = 1'b0;
    radio_up = 1'b1;
    clk_en = 1'b1;
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;

    rd(8'h3c, rv); chk(rv, 32'h0020_0420);
    rd(8'h34, rv); chk(rv, 32'h0000_0000);
    rd(8'h80, rv); chk(rv, 32'h0000_0000);
    rd(8'h44, rv); chk(rv, 32'h0000_0000);
    wr(8'h34, 32'h1234_5678);
    rd(8'h34, rv); chk(rv, 32'h1234_5678);
    $display("test registers done");

    // Each of the 24 layouts: last legal byte passes, first byte beyond faults
    for (int l = 0; l < 24; l++)
    begin
      wr(8'h80, 32'(l));
      chk(32'(layout), 32'(l));
      xacc(17'((l + 1) * 2048 - 1));
      chk(32'(err_irq), 32'h0);
      xacc(17'((l + 1) * 2048));
      chk(32'(err_irq), 32'h1);
      wr(8'h80, 32'(l) | 32'h0000_0200);
      chk(32'(err_irq), 32'h0);
    end
    wr(8'h80, 32'h0000_0018);
    xacc(17'h0_0000);
    rd(8'h80, rv); chk(rv, 32'h0000_0418);
    wr(8'h80, 32'h0000_0218);
    rd(8'h80, rv); chk(rv, 32'h0000_0018);
    gen_err = 1'b1;
    @(posedge clk);
    #1 chk(32'(err_irq), 32'h1);
    gen_err = 1'b0;
    @(posedge clk);
    #1 chk(32'(err_irq), 32'h0);
    wr(8'h80, 32'h0000_0000);
    $display("test exchange memory done");

    // Timed wake: assert lead 3, deassert lead 1, external time 3
    wr(8'h3c, 32'h0030_0403);
    wr(8'h34, 32'h0000_0006);
    wr(8'h30, 32'h0000_0001);
    @(posedge clk);
    #1 chk(32'(pdn), 32'h1);
    chk(32'(lp_sel), 32'h1);
    run_sleep(300, hi, first_ok, exited);
    chk(32'(exited), 32'h1);
    chk(32'(first_ok), 32'h1);
    chk(32'(hi), 32'(2 * LPD));
    chk(32'(pdn), 32'h0);
    rd(8'h38, rv);
    chk(32'(rv >= 32'h5 && rv <= 32'h7), 32'h1);
    rd(8'h30, rv); chk(rv, 32'h0000_0000);
    $display("test timed wake done");

    // Power and clocks held off past expiry keep the core asleep
    wr(8'h30, 32'h0000_0001);
    rd(8'h80, rv);
    chk(rv, 32'h0000_0800);
    radio_up = 1'b0;
    clk_en = 1'b0;
    run_sleep(240, hi, first_ok, exited);
    chk(32'(exited), 32'h0);
    chk(32'(pdn), 32'h1);
    radio_up = 1'b1;
    run_sleep(20, hi, first_ok, exited);
    chk(32'(exited), 32'h0);
    clk_en = 1'b1;
    run_sleep(10, hi, first_ok, exited);
    chk(32'(exited), 32'h1);
    rd(8'h38, rv);
    chk(32'(rv > 32'h28), 32'h1);
    $display("test late power-up done");

    // Forced wake, then entry while the request is still held
    wr(8'h34, 32'h0000_0064);
    wr(8'h30, 32'h0000_0001);
    repeat (10) @(posedge clk);
    wr(8'h80, 32'h0000_0100);
    @(posedge clk);
    #1 chk(32'(early), 32'h1);
    run_sleep(300, hi, first_ok, exited);
    chk(32'(exited), 32'h1);
    chk(32'(first_ok), 32'h1);
    chk(32'(hi >= LPD && hi <= 3 * LPD + 2), 32'h1);
    wr(8'h30, 32'h0000_0001);
    repeat (3) @(posedge clk);
    #1 chk(32'(pdn), 32'h0);
    wr(8'h80, 32'h0000_0000);
    $display("test forced wake done");

    // Request ignored while external wake is disabled
    wr(8'h34, 32'h0000_0020);
    wr(8'h30, 32'h0000_0003);
    repeat (3) @(posedge clk);
    wr(8'h80, 32'h0000_0100);
    repeat (4) @(posedge clk);
    #1 chk(32'(early), 32'h0);
    chk(32'(pdn), 32'h1);
    wr(8'h80, 32'h0000_0000);
    run_sleep(400, hi, first_ok, exited);
    chk(32'(exited), 32'h1);
    chk(32'(hi), 32'(2 * LPD));
    rd(8'h30, rv); chk(rv, 32'h0000_0002);
    $display("test wake disable done");

    // Zero assert lead: no timed pulse, so one late early wake pulse before exit
    wr(8'h3c, 32'h0030_0400);
    wr(8'h34, 32'h0000_0006);
    wr(8'h30, 32'h0000_0001);
    run_sleep(300, hi, first_ok, exited);
    chk(32'(exited), 32'h1);
    chk(32'(first_ok), 32'h1);
    chk(32'(hi), 32'h1);
    rd(8'h38, rv);
    chk(32'(rv >= 32'h6 && rv <= 32'h7), 32'h1);
    $display("test short lead done");
    wrap_up();
  end
endmodule // tb
